// file: tb/adc_seq_chk.sv
// port assertions for adc_sequencer, bound under it
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
module adc_seq_chk #(
  parameter int unsigned MCYCLE_CLKS  = 12,
  parameter int unsigned CONV_MCYCLES = 4
) (
  input wire logic        CLK,
  input wire logic        RESET,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [7:0]  S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        CONVERSION_START,
  input wire logic        CONVERTING
);
  import adc_seq_pkg::*;
  localparam int unsigned SLOT = MCYCLE_CLKS * CONV_MCYCLES;
  logic [15:0] gap_reg;
  logic [2:0]  idx_reg;
  wire mapped = S_AXI_ARADDR[1:0] == 2'b00 && (S_AXI_ARADDR <= OFF_IRQ_MASK
    || S_AXI_ARADDR >= OFF_RESULT_BASE && S_AXI_ARADDR <= OFF_RESULT_LAST);
  // gap restarts per run, so the first slot of a cycle is never judged
  always_ff @(posedge CLK) begin
    if (RESET || !CONVERTING) gap_reg <= 16'h0000;
    else gap_reg <= CONVERSION_START ? 16'h0001 : gap_reg + 16'h0001;
  end
  always_ff @(posedge CLK) begin
    if (RESET || !CONVERTING) idx_reg <= 3'h0;
    else if (CONVERSION_START) idx_reg <= idx_reg + 3'h1;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence wr_offer;
    S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID && !S_AXI_AWREADY
    && !$past(S_AXI_BVALID);
  endsequence
  sequence rd_offer;
    S_AXI_ARVALID && !S_AXI_RVALID && !S_AXI_ARREADY && !$past(S_AXI_RVALID);
  endsequence
  wr_take_a: assert property (wr_offer |=> S_AXI_AWREADY && S_AXI_WREADY
    && S_AXI_BVALID) else $error("write not taken");
  rd_take_a: assert property (rd_offer |=> S_AXI_ARREADY && S_AXI_RVALID)
    else $error("read not taken");
  rd_resp_a: assert property (rd_offer |=> S_AXI_RRESP ==
    ($past(mapped) ? RESP_OKAY : RESP_SLVERR)) else $error("bad read resp");
  err_data_a: assert property (S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR
    |-> S_AXI_RDATA == 32'h0000_0000) else $error("error data not zero");
  bvalid_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID) else $error("bvalid dropped");
  rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data moved");
  start_run_a: assert property (CONVERSION_START |-> CONVERTING)
    else $error("start outside a run");
  slot_gap_a: assert property (CONVERSION_START && idx_reg != 3'h0
    |-> gap_reg == 16'(SLOT)) else $error("slot length wrong");
endmodule // adc_seq_chk
bind adc_sequencer adc_seq_chk #(.MCYCLE_CLKS(MCYCLE_CLKS),
  .CONV_MCYCLES(CONV_MCYCLES)) adc_seq_chk_inst (.CLK, .RESET,
  .S_AXI_AWVALID, .S_AXI_WVALID, .S_AXI_AWREADY, .S_AXI_WREADY,
  .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
  .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA,
  .S_AXI_RRESP, .CONVERSION_START, .CONVERTING);

// file: tb/analog_src_model.sv
// analog inputs: channel n reads 0x20 times n plus a bench bias
// assumes channel select holds steady through a conversion window
`timescale 1ns/1ps
module analog_src_model (
  input  wire logic [2:0] chan,
  input  wire logic [7:0] bias,
  output logic      [7:0] sample,
  output logic            above
);
  assign sample = {chan, 5'h00} + bias;
  // strict greater-than, so a level equal to the reference reads low
  assign above = sample > 8'h80;
endmodule // analog_src_model

// file: tb/tb_top.sv
// bench for adc_sequencer: axi4-lite master, trigger pin, analog model
// assumes shortened machine cycles and the bound port checker
`timescale 1ns/1ps
module tb_top;
  import adc_seq_pkg::*;
  localparam int MC = 2;
  logic        CLK = 1'b0;
  logic        RESET = 1'b1;
  logic        S_AXI_AWVALID = 1'b0;
  logic        S_AXI_WVALID = 1'b0;
  logic        S_AXI_BREADY = 1'b0;
  logic        S_AXI_ARVALID = 1'b0;
  logic        S_AXI_RREADY = 1'b0;
  logic        EXTERNAL_TRIGGER_IN = 1'b1;
  logic [7:0]  S_AXI_AWADDR = 8'h00;
  logic [7:0]  S_AXI_ARADDR = 8'h00;
  logic [7:0]  bias = 8'h00;
  logic [3:0]  S_AXI_WSTRB = 4'hF;
  logic [31:0] S_AXI_WDATA = 32'h0;
  logic [31:0] S_AXI_RDATA, rd_data;
  logic [7:0]  SAMPLE_DATA;
  logic [2:0]  ANALOG_CHANNEL_SEL;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic        S_AXI_RVALID, SAMPLE_ABOVE_THRESHOLD, CONVERSION_START;
  logic        CONVERTING, IRQ;
  int          mismatches = 0;
  int          num_checks = 0;
  int          scan_len, len;
  always #2.5 CLK = ~CLK;
  adc_sequencer #(.MCYCLE_CLKS(MC), .CONV_MCYCLES(1)) adc_sequencer_inst (
    .CLK, .RESET, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
    .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
    .S_AXI_RREADY, .EXTERNAL_TRIGGER_IN, .SAMPLE_DATA,
    .SAMPLE_ABOVE_THRESHOLD, .ANALOG_CHANNEL_SEL, .CONVERSION_START,
    .CONVERTING, .IRQ);
  analog_src_model analog_src_model_inst (.chan(ANALOG_CHANNEL_SEL),
    .bias, .sample(SAMPLE_DATA), .above(SAMPLE_ABOVE_THRESHOLD));
  task automatic chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic hang;
    mismatches++;
    give_verdict();
  endtask
  // ready is raised on the first edge, the same edge the slave raises valid, so no answer is held
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [1:0] er);
    logic ok;
    S_AXI_AWADDR <= a;
    S_AXI_ARADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= w;
    S_AXI_WVALID <= w;
    S_AXI_ARVALID <= !w;
    ok = 1'b0;
    for (int n = 0; !ok; n++) begin
      @(posedge CLK);
      if (n > 50) hang();
      ok = w ? (S_AXI_BVALID & S_AXI_BREADY) === 1'b1
             : (S_AXI_RVALID & S_AXI_RREADY) === 1'b1;
      if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
      if (S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
      S_AXI_BREADY <= w && !ok;
      S_AXI_RREADY <= !w && !ok;
    end
    rd_data = S_AXI_RDATA;
    chk(w ? S_AXI_BRESP : S_AXI_RRESP, er);
    @(posedge CLK);
  endtask
  task automatic sc_regs;
    xfer(1'b0, OFF_CONTROL, 32'h0, RESP_OKAY);
    chk(rd_data, 32'h0000_0000);
    xfer(1'b1, 8'h10, 32'h0000_00FF, RESP_SLVERR);
    xfer(1'b0, 8'h10, 32'h0, RESP_SLVERR);
    chk(rd_data, 32'h0000_0000);
  endtask
  task automatic run_ext(input logic [7:0] c, b, input logic m,
                         output int n);
    logic [7:0] v, cmp;
    logic [2:0] ch;
    bias <= b;
    xfer(1'b1, OFF_IRQ_MASK, {31'h0, m}, RESP_OKAY);
    xfer(1'b1, OFF_CONTROL, {24'h0, c}, RESP_OKAY);
    repeat (3 * MC) @(posedge CLK);
    EXTERNAL_TRIGGER_IN <= 1'b0; // high, then low, each for over a cycle
    repeat (3 * MC) @(posedge CLK);
    EXTERNAL_TRIGGER_IN <= 1'b1;
    for (n = 0; CONVERTING !== 1'b1 && n < 100; n++) @(posedge CLK);
    if (n >= 100) hang();
    for (n = 0; CONVERTING === 1'b1 && n < 400; n++) begin
      @(posedge CLK);
      EXTERNAL_TRIGGER_IN <= n < 2 || n > 5; // edge inside the run
    end
    if (n >= 400) hang();
    repeat (40) @(posedge CLK);
    chk(CONVERTING, 1'b0);
    cmp = 8'h00;
    for (int i = 0; i < 8; i++) begin
      ch = (c[3] && i < 4) ? {1'b0, c[2:1]} : i[2:0];
      v = {ch, 5'h00} + b;
      cmp[7 - i] = v > 8'h80;
      xfer(1'b0, OFF_RESULT_BASE + 8'(4 * i), 32'h0, RESP_OKAY);
      chk(rd_data, {24'h0, v});
    end
    xfer(1'b0, OFF_COMPARE, 32'h0, RESP_OKAY);
    chk(rd_data, {24'h0, cmp});
    xfer(1'b0, OFF_IRQ_STATUS, 32'h0, RESP_OKAY);
    chk(rd_data, 32'h0000_0001);
    chk(IRQ, m);
    xfer(1'b1, OFF_IRQ_STATUS, 32'h0000_0001, RESP_OKAY);
    @(posedge CLK);
    chk(IRQ, 1'b0);
  endtask
  task automatic sc_ro;
    logic [31:0] old;
    for (int i = 0; i < 2; i++) begin
      xfer(1'b0, i ? OFF_RESULT_LAST : OFF_COMPARE, 32'h0, RESP_OKAY);
      old = rd_data;
      xfer(1'b1, i ? OFF_RESULT_LAST : OFF_COMPARE, ~old, RESP_OKAY);
      xfer(1'b0, i ? OFF_RESULT_LAST : OFF_COMPARE, 32'h0, RESP_OKAY);
      chk(rd_data, old);
    end
  endtask
  task automatic sc_int;
    int n;
    bias <= 8'h03;
    xfer(1'b1, OFF_IRQ_MASK, 32'h0000_0001, RESP_OKAY);
    xfer(1'b1, OFF_CONTROL, 32'h0000_0001, RESP_OKAY);
    for (n = 0; CONVERTING !== 1'b1 && n < 50; n++) @(posedge CLK);
    if (n >= 50) hang();
    chk(n <= 2 * MC, 1'b1);
    repeat (40) @(posedge CLK);
    bias <= 8'h11;
    xfer(1'b1, OFF_IRQ_STATUS, 32'h0000_0001, RESP_OKAY);
    repeat (40) @(posedge CLK);
    xfer(1'b0, OFF_RESULT_BASE, 32'h0, RESP_OKAY);
    chk(rd_data, 32'h0000_0011);
    chk(IRQ, 1'b1);
    xfer(1'b1, OFF_CONTROL, 32'h0, RESP_OKAY);
    n = 0;
    repeat (40) begin
      @(posedge CLK);
      if (CONVERSION_START !== 1'b0) n++;
    end
    chk({n[30:0], CONVERTING}, 32'h0);
  endtask
  initial begin
    repeat (10) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    sc_regs();
    run_ext(8'h11, 8'h00, 1'b1, scan_len);
    for (int s = 0; s < 4; s++) begin
      run_ext(8'h19 | 8'(s << 1), 8'h07, 1'b0, len);
      chk(len, scan_len);
    end
    sc_ro();
    sc_int();
    give_verdict();
  end
endmodule // tb_top

// file: verilog/adc_seq_pkg.sv
// constants, register map and types for the converter sequencer
// assumes a 32-bit axi4-lite master and one 200 MHz clock
//
// Behaviour
// RL1: each result register updates as its conversion ends, lowest slot to 7
// RL2: compare register holds channel 0 in the msb, channel 7 in the lsb
// RL3: compare bit is 1 when input exceeds threshold, else 0
// RL4: comparison runs on every conversion while enabled, in both input modes
// RL5: internal trigger starts conversions the machine cycle after enable
// RL6: done flag sets when channel 7 finishes and can raise the interrupt
// RL7: internal trigger restarts a new cycle at slot 0 while enabled
// RL8: clearing enable stops all conversion activity
// RL9: external pin sampled once per machine cycle, high then low is an edge
// RL10: trigger source holds pin high one machine cycle, then low one
// RL11: external edge starts next machine cycle, runs to 7, flags, halts
// RL12: external edges during a running cycle are ignored
// RL13: scan mode converts channels 0 to 7 into matching result registers
// RL14: select mode converts chosen channel four times, then channels 4 to 7
// RL15: two-bit select field picks channel 0, 1, 2 or 3
// RL16: select cycle lasts exactly as long as a scan cycle
// RL17: done flag stays until software clears; result writes are ignored
package adc_seq_pkg;
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned ADDR_W           = 8;
  localparam int unsigned DATA_W           = 32;
  localparam int unsigned NUM_CH           = 8;
  localparam int unsigned SAMPLE_W         = 8;
  localparam int unsigned MCYCLE_NS        = 60;
  localparam int unsigned MCYCLE_CLKS      = (MCYCLE_NS * CLK_MHZ) / 1000;
  localparam int unsigned CONV_MCYCLES     = 4;

  localparam logic [7:0] OFF_CONTROL       = 8'h00;
  localparam logic [7:0] OFF_COMPARE       = 8'h04;
  localparam logic [7:0] OFF_IRQ_STATUS    = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK      = 8'h0C;
  localparam logic [7:0] OFF_RESULT_BASE   = 8'h20;
  localparam logic [7:0] OFF_RESULT_LAST   = 8'h3C;

  localparam int unsigned BIT_ENABLE       = 0;
  localparam int unsigned BIT_SEL_LO       = 1;
  localparam int unsigned BIT_SEL_HI       = 2;
  localparam int unsigned BIT_MODE         = 3;
  localparam int unsigned BIT_TRIG_SRC     = 4;
  localparam int unsigned BIT_DONE         = 5;
  localparam int unsigned BIT_IRQ_DONE     = 0;

  localparam logic [4:0] CONTROL_RESET     = 5'h00;
  localparam logic [1:0] RESP_OKAY         = 2'b00;
  localparam logic [1:0] RESP_SLVERR       = 2'b10;
  localparam logic [2:0] LAST_SLOT         = 3'h7;
  localparam logic [2:0] FIRST_UPPER_SLOT  = 3'h4;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_RUN  = 2'b10
  } seq_state_t;
endpackage

// file: verilog/adc_sequencer.sv
// sequencer, trigger control and axi4-lite register file of the converter
// assumes an outside sar converter that has a sample ready and a compare
// result valid by the end of each conversion window
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module adc_sequencer #(
  parameter int unsigned MCYCLE_CLKS  = adc_seq_pkg::MCYCLE_CLKS,
  parameter int unsigned CONV_MCYCLES = adc_seq_pkg::CONV_MCYCLES
) (
  input  wire logic                             CLK,
  input  wire logic                             RESET,
  input  wire logic [adc_seq_pkg::ADDR_W-1:0]   S_AXI_AWADDR,
  input  wire logic                             S_AXI_AWVALID,
  output logic                                  S_AXI_AWREADY,
  input  wire logic [adc_seq_pkg::DATA_W-1:0]   S_AXI_WDATA,
  input  wire logic [3:0]                       S_AXI_WSTRB,
  input  wire logic                             S_AXI_WVALID,
  output logic                                  S_AXI_WREADY,
  output logic [1:0]                            S_AXI_BRESP,
  output logic                                  S_AXI_BVALID,
  input  wire logic                             S_AXI_BREADY,
  input  wire logic [adc_seq_pkg::ADDR_W-1:0]   S_AXI_ARADDR,
  input  wire logic                             S_AXI_ARVALID,
  output logic                                  S_AXI_ARREADY,
  output logic [adc_seq_pkg::DATA_W-1:0]        S_AXI_RDATA,
  output logic [1:0]                            S_AXI_RRESP,
  output logic                                  S_AXI_RVALID,
  input  wire logic                             S_AXI_RREADY,
  input  wire logic                             EXTERNAL_TRIGGER_IN,
  input  wire logic [adc_seq_pkg::SAMPLE_W-1:0] SAMPLE_DATA,
  input  wire logic                             SAMPLE_ABOVE_THRESHOLD,
  output logic [2:0]                            ANALOG_CHANNEL_SEL,
  output logic                                  CONVERSION_START,
  output logic                                  CONVERTING,
  output logic                                  IRQ
);
  import adc_seq_pkg::*;

  localparam int unsigned DIV_W  = $clog2(MCYCLE_CLKS + 1);
  localparam int unsigned CONV_W = $clog2(CONV_MCYCLES + 1);
  localparam logic [DIV_W-1:0]  DIV_LAST  = DIV_W'(MCYCLE_CLKS - 1);
  localparam logic [CONV_W-1:0] CONV_LAST = CONV_W'(CONV_MCYCLES - 1);

  // register file
  logic [4:0]          control_reg;
  logic [7:0]          compare_reg;
  logic                done_reg;
  logic                mask_reg;
  logic [SAMPLE_W-1:0] result_mem [NUM_CH];

  // sequencer
  seq_state_t          state_reg;
  logic [2:0]          slot_reg;
  logic [CONV_W-1:0]   conv_cnt_reg;
  logic [DIV_W-1:0]    div_reg;
  logic                tick_reg;
  logic                enable_seen_reg;

  // trigger pin synchroniser and per-machine-cycle sample
  logic                trig_s1_reg;
  logic                trig_s2_reg;
  logic                trig_s3_reg;
  logic                trig_level_reg;
  logic                trig_prev_sample_reg;
  logic                trig_edge_reg;

  // axi handshakes
  logic                aw_take;
  logic                ar_take;
  logic                wr_ctrl;
  logic                wr_status;
  logic                wr_mask;
  logic                wr_mapped;
  logic                rd_mapped;
  logic [DATA_W-1:0]   rd_word;

  function automatic logic is_result(input logic [ADDR_W-1:0] a);
    return a >= OFF_RESULT_BASE && a <= OFF_RESULT_LAST && a[1:0] == 2'b00;
  endfunction

  function automatic logic [2:0] result_index(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - OFF_RESULT_BASE;
    return d[4:2];
  endfunction

  function automatic logic is_reg(input logic [ADDR_W-1:0] a);
    return a == OFF_CONTROL || a == OFF_COMPARE || a == OFF_IRQ_STATUS ||
           a == OFF_IRQ_MASK || is_result(a);
  endfunction

  wire enable      = control_reg[BIT_ENABLE];
  wire select_mode = control_reg[BIT_MODE];
  wire ext_trigger = control_reg[BIT_TRIG_SRC];
  wire [1:0] sel_field = {control_reg[BIT_SEL_HI], control_reg[BIT_SEL_LO]};

  // slots 0..3 repeat the chosen channel, so both modes take eight slots
  wire       repeat_slot = select_mode && slot_reg < FIRST_UPPER_SLOT;
  wire [2:0] slot_channel = repeat_slot ? {1'b0, sel_field}   // [RL14] [RL15]
                                        : slot_reg;           // [RL13] [RL16]
  wire conv_end   = state_reg == SEQ_RUN && tick_reg && conv_cnt_reg == CONV_LAST;
  wire cycle_end  = conv_end && slot_reg == LAST_SLOT;
  wire int_start  = !ext_trigger && enable_seen_reg;            // [RL5]
  wire ext_start  = ext_trigger && trig_edge_reg;               // [RL11]
  wire start_cyc  = state_reg == SEQ_IDLE && enable && tick_reg &&
                    (int_start || ext_start);
  wire restart    = cycle_end && !ext_trigger;                  // [RL7]

  assign aw_take   = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID &&
                     !S_AXI_AWREADY;
  assign ar_take   = S_AXI_ARVALID && !S_AXI_RVALID && !S_AXI_ARREADY;
  assign wr_mapped = is_reg(S_AXI_AWADDR);
  assign rd_mapped = is_reg(S_AXI_ARADDR);
  assign wr_ctrl   = aw_take && S_AXI_WSTRB[0] && S_AXI_AWADDR == OFF_CONTROL;
  assign wr_status = aw_take && S_AXI_WSTRB[0] &&
                     S_AXI_AWADDR == OFF_IRQ_STATUS;
  assign wr_mask   = aw_take && S_AXI_WSTRB[0] && S_AXI_AWADDR == OFF_IRQ_MASK;

  // compare register and results are read only: writes land nowhere [RL17]
  assign rd_word =
    S_AXI_ARADDR == OFF_CONTROL    ? DATA_W'({done_reg, control_reg}) :
    S_AXI_ARADDR == OFF_COMPARE    ? DATA_W'(compare_reg) :
    S_AXI_ARADDR == OFF_IRQ_STATUS ? DATA_W'(done_reg) :
    S_AXI_ARADDR == OFF_IRQ_MASK   ? DATA_W'(mask_reg) :
    is_result(S_AXI_ARADDR)        ?
      DATA_W'(result_mem[result_index(S_AXI_ARADDR)]) : '0;

  // write channel: address and data taken together in one cycle
  always_ff @(posedge CLK) begin
    if (RESET) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= aw_take;
      S_AXI_WREADY  <= aw_take;
      if (aw_take) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // read channel
  always_ff @(posedge CLK) begin
    if (RESET) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= '0;
      S_AXI_RRESP   <= RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= ar_take;
      if (ar_take) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= rd_word;
        S_AXI_RRESP  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // control, mask and done flag; a set in the clearing cycle wins
  always_ff @(posedge CLK) begin
    if (RESET) begin
      control_reg <= CONTROL_RESET;
      mask_reg    <= 1'b0;
      done_reg    <= 1'b0;
    end else begin
      if (wr_ctrl)
        control_reg <= S_AXI_WDATA[4:0];
      if (wr_mask)
        mask_reg <= S_AXI_WDATA[BIT_IRQ_DONE];
      if (cycle_end)
        done_reg <= 1'b1;                                       // [RL6]
      else if (wr_status && S_AXI_WDATA[BIT_IRQ_DONE])
        done_reg <= 1'b0;                                       // [RL17]
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET)
      IRQ <= 1'b0;
    else
      IRQ <= done_reg && mask_reg;                              // [RL6]
  end

  // machine-cycle enable from a divider
  always_ff @(posedge CLK) begin
    if (RESET) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= div_reg == DIV_LAST;
      div_reg  <= div_reg == DIV_LAST ? '0 : div_reg + 1'b1;
    end
  end

  // a rise of enable is held while enable stays set, for the next machine cycle to pick up
  always_ff @(posedge CLK) begin
    if (RESET)
      enable_seen_reg <= 1'b0;
    else if (!enable)
      enable_seen_reg <= 1'b0;
    else if (wr_ctrl || state_reg == SEQ_IDLE)
      enable_seen_reg <= 1'b1;
  end

  // pin crosses three flops; the level moves once stages two and three agree
  always_ff @(posedge CLK) begin
    if (RESET) begin
      trig_s1_reg    <= 1'b0;
      trig_s2_reg    <= 1'b0;
      trig_s3_reg    <= 1'b0;
      trig_level_reg <= 1'b0;
    end else begin
      trig_s1_reg <= EXTERNAL_TRIGGER_IN;
      trig_s2_reg <= trig_s1_reg;
      trig_s3_reg <= trig_s2_reg;
      if (trig_s2_reg == trig_s3_reg)
        trig_level_reg <= trig_s3_reg;
    end
  end

  // no true edge detector: one sample per machine cycle, high then low
  always_ff @(posedge CLK) begin
    if (RESET) begin
      trig_prev_sample_reg <= 1'b0;
      trig_edge_reg        <= 1'b0;
    end else if (tick_reg) begin
      trig_prev_sample_reg <= trig_level_reg;                   // [RL9]
      trig_edge_reg <= trig_prev_sample_reg && !trig_level_reg  // [RL9]
                       && state_reg == SEQ_IDLE;                // [RL12]
    end
  end

  // sequencer state
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_reg    <= SEQ_IDLE;
      slot_reg     <= '0;
      conv_cnt_reg <= '0;
    end else if (!enable) begin
      state_reg    <= SEQ_IDLE;                                 // [RL8]
      slot_reg     <= '0;
      conv_cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        SEQ_IDLE: begin
          if (start_cyc) begin
            state_reg    <= SEQ_RUN;
            slot_reg     <= '0;
            conv_cnt_reg <= '0;
          end
        end
        SEQ_RUN: begin
          if (tick_reg) begin
            conv_cnt_reg <= conv_end ? '0 : conv_cnt_reg + 1'b1;
            if (conv_end)
              slot_reg <= slot_reg + 1'b1;                      // [RL1]
            if (cycle_end && !restart)
              state_reg <= SEQ_IDLE;                            // [RL11]
          end
        end
      endcase
    end
  end

  // results and comparison bits land as each conversion ends
  always_ff @(posedge CLK) begin
    if (RESET) begin
      compare_reg <= '0;
    end else if (conv_end && enable) begin
      result_mem[slot_reg] <= SAMPLE_DATA;                      // [RL1]
      compare_reg[LAST_SLOT - slot_reg] <=                      // [RL2] [RL4]
        SAMPLE_ABOVE_THRESHOLD;                                 // [RL3]
    end
  end

  // results have no reset: software must wait for the first done flag
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ANALOG_CHANNEL_SEL <= '0;
      CONVERSION_START   <= 1'b0;
      CONVERTING         <= 1'b0;
    end else begin
      ANALOG_CHANNEL_SEL <= slot_channel;
      CONVERSION_START   <= enable && state_reg == SEQ_RUN && tick_reg &&
                            conv_cnt_reg == '0;
      CONVERTING         <= state_reg == SEQ_RUN && enable;
    end
  end
endmodule // adc_sequencer
